/* File: verilog/ipr_pkg.sv */
// Package for the interrupt priority slice: map, fields, carriers
package ipr_pkg;

  // ---------------------------------------------------------------
  // Widths and source count
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned REG_W    = 16;
  localparam int unsigned FLD_W    = 2;
  localparam int unsigned NUM_SRC  = 15;

  // ---------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] IDX_PRIO_4 = 12'h004;
  localparam logic [ADDR_W-1:0] IDX_PRIO_5 = 12'h005;
  localparam logic [ADDR_W-1:0] IDX_PRIO_6 = 12'h006;
  localparam int unsigned       IDX_SHIFT  = 2;

  // ---------------------------------------------------------------
  // Reset values and writable-bit masks
  // ---------------------------------------------------------------
  localparam logic [REG_W-1:0] RST_PRIO   = 16'h0000;
  localparam logic [REG_W-1:0] WMASK_PRIO_4 = 16'h0003;
  localparam logic [REG_W-1:0] WMASK_PRIO_5 = 16'hFF3F;
  localparam logic [REG_W-1:0] WMASK_PRIO_6 = 16'hFFCF;

  // ---------------------------------------------------------------
  // Field codes
  // ---------------------------------------------------------------
  localparam logic [FLD_W-1:0] CODE_DISABLED = 2'h0;
  localparam logic [FLD_W-1:0] LEVEL_MAX     = 2'h2;

  // ---------------------------------------------------------------
  // Field low-bit positions inside their registers
  // ---------------------------------------------------------------
  localparam int unsigned LSB_PORT_C_PIN         = 0;   // offset 4
  localparam int unsigned LSB_DEC1_INDEX         = 14;  // offset 5
  localparam int unsigned LSB_DEC1_HOME_WDOG     = 12;
  localparam int unsigned LSB_SER1_RX_FULL       = 10;
  localparam int unsigned LSB_SER1_RX_ERROR      = 8;
  localparam int unsigned LSB_SER1_TX_IDLE       = 4;
  localparam int unsigned LSB_SER1_TX_EMPTY      = 2;
  localparam int unsigned LSB_SPI0_TX_EMPTY      = 0;
  localparam int unsigned LSB_TMR3_CH0           = 14;  // offset 6
  localparam int unsigned LSB_TMR4_CH3           = 12;
  localparam int unsigned LSB_TMR4_CH2           = 10;
  localparam int unsigned LSB_TMR4_CH1           = 8;
  localparam int unsigned LSB_TMR4_CH0           = 6;
  localparam int unsigned LSB_DEC0_INDEX         = 2;
  localparam int unsigned LSB_DEC0_HOME_WDOG     = 0;

  // ---------------------------------------------------------------
  // Source numbering on the per-source ports
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    SRC_PORT_C_PIN     = 4'h0,
    SRC_DEC1_INDEX     = 4'h1,
    SRC_DEC1_HOME_WDOG = 4'h2,
    SRC_SER1_RX_FULL   = 4'h3,
    SRC_SER1_RX_ERROR  = 4'h4,
    SRC_SER1_TX_IDLE   = 4'h5,
    SRC_SER1_TX_EMPTY  = 4'h6,
    SRC_SPI0_TX_EMPTY  = 4'h7,
    SRC_TMR3_CH0       = 4'h8,
    SRC_TMR4_CH3       = 4'h9,
    SRC_TMR4_CH2       = 4'hA,
    SRC_TMR4_CH1       = 4'hB,
    SRC_TMR4_CH0       = 4'hC,
    SRC_DEC0_INDEX     = 4'hD,
    SRC_DEC0_HOME_WDOG = 4'hE
  } ipr_src_t;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } ipr_apb_req_t;

  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
  } ipr_apb_rsp_t;

  typedef struct packed {
    logic             enable;
    logic             req;
    logic [FLD_W-1:0] level;
  } ipr_src_out_t;

  // Whole state of the register slice
  typedef struct packed {
    ipr_apb_rsp_t                  rsp;
    logic [REG_W-1:0]              prio_4;
    logic [REG_W-1:0]              prio_5;
    logic [REG_W-1:0]              prio_6;
    logic [NUM_SRC-1:0]            src_en;
    logic [NUM_SRC-1:0]            src_req;
    logic [NUM_SRC-1:0][FLD_W-1:0] src_lvl;
  } ipr_state_t;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] idx_to_addr(
    input logic [ADDR_W-1:0] idx
  );
    return ADDR_W'(idx << IDX_SHIFT);
  endfunction : idx_to_addr

  // Code to level: 01 -> 0, 10 -> 1, 11 -> 2, 00 -> 0 (disabled)
  function automatic logic [FLD_W-1:0] code_to_level(
    input logic [FLD_W-1:0] code
  );
    logic [FLD_W-1:0] lvl;
    lvl = (code == CODE_DISABLED) ? CODE_DISABLED
                                  : FLD_W'(code - 2'h1);
    return (lvl > LEVEL_MAX) ? LEVEL_MAX : lvl;
  endfunction : code_to_level

endpackage : ipr_pkg

/* File: verilog/ipr_apb_decode.sv */
// APB phase and address decode for the priority slice
module ipr_apb_decode (
  // Bus request
  input  ipr_pkg::ipr_apb_req_t req_i,
  // Decoded phase and target
  output logic                  setup_o,
  output logic                  access_o,
  output logic                  hit_o,
  output logic [2:0]            sel_o
);

  // ---------------------------------------------------------------
  // Phase decode
  // ---------------------------------------------------------------
  assign setup_o  = req_i.psel & ~req_i.penable;
  assign access_o = req_i.psel & req_i.penable;

  // ---------------------------------------------------------------
  // Address decode, one-hot: bit0 offset 4, bit1 offset 5, bit2 offset 6
  // ---------------------------------------------------------------
  always_comb begin
    sel_o[0] = (req_i.paddr == ipr_pkg::idx_to_addr(ipr_pkg::IDX_PRIO_4));
    sel_o[1] = (req_i.paddr == ipr_pkg::idx_to_addr(ipr_pkg::IDX_PRIO_5));
    sel_o[2] = (req_i.paddr == ipr_pkg::idx_to_addr(ipr_pkg::IDX_PRIO_6));
    hit_o    = |sel_o;
  end

endmodule : ipr_apb_decode

/* File: verilog/ipr_field_decode.sv */
// Decodes one 2-bit priority field into enable, level and gated request
module ipr_field_decode (
  // Field and raw source event
  input  wire logic [ipr_pkg::FLD_W-1:0] code_i,
  input  wire logic                      irq_i,
  // Decoded view
  output ipr_pkg::ipr_src_out_t          out_o
);

  // Disabled code blocks the source, others give level code minus one
  always_comb begin
    out_o.enable = (code_i != ipr_pkg::CODE_DISABLED);
    out_o.req    = irq_i & out_o.enable;
    out_o.level  = ipr_pkg::code_to_level(code_i);
  end

endmodule : ipr_field_decode

/* File: verilog/ipr_prio_regs.sv */
// Interrupt priority registers at offsets 4 (low field), 5 and 6
//
// Summary of operation
// - Code 00 disables source, no request
// - Code 01 enables at level 0
// - Code 10 enables at level 1
// - Code 11 enables at level 2
// - Levels never exceed 2
// - All fields reset to disabled
// - Reserved pairs read zero, ignore writes
// - Offset-5 register, 16 bits, resets zero
// - Offset-6 register, 16 bits, resets zero
// - Offset-4 bits 1-0: port C pins
// - Offset-5 bits 15-14: decoder 1 index
// - Offset-5 bits 13-12: decoder 1 home/watchdog
// - Offset-5 bits 11-10: serial 1 rx full
// - Offset-5 bits 9-8: serial 1 rx error
// - Offset-5 bits 5-4: serial 1 tx idle
// - Offset-5 bits 3-2: serial 1 tx empty
// - Offset-5 bits 1-0: SPI 0 tx empty
// - Offset-6 bits 15-14: timer group 3 ch0
// - Offset-6 bits 13-12: timer group 4 ch3
// - Offset-6 bits 11-10: timer group 4 ch2
// - Offset-6 bits 9-8: timer group 4 ch1
// - Offset-6 bits 7-6: timer group 4 ch0
// - Offset-6 bits 3-2: decoder 0 index
// - Offset-6 bits 1-0: decoder 0 home/watchdog
module ipr_prio_regs (
  // Clock and reset
  input  wire logic                      ref_clk_i,
  input  wire logic                      rst_n_i,
  // APB slave
  input  ipr_pkg::ipr_apb_req_t          apb_req_i,
  output ipr_pkg::ipr_apb_rsp_t          apb_rsp_o,
  // Raw source events, indexed by ipr_pkg::ipr_src_t
  input  wire logic [ipr_pkg::NUM_SRC-1:0] src_irq_i,
  // Per-source view toward the arbiter
  output logic [ipr_pkg::NUM_SRC-1:0]    src_en_o,
  output logic [ipr_pkg::NUM_SRC-1:0]    src_req_o,
  output logic [ipr_pkg::NUM_SRC-1:0][ipr_pkg::FLD_W-1:0] src_level_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  ipr_pkg::ipr_state_t s_reg;
  ipr_pkg::ipr_state_t s_next;

  logic        bus_setup;
  logic        bus_access;
  logic        bus_hit;
  logic [2:0]  bus_sel;
  logic        wr_commit;
  logic [ipr_pkg::REG_W-1:0] wr_data;

  logic [ipr_pkg::NUM_SRC-1:0][ipr_pkg::FLD_W-1:0] fld;
  ipr_pkg::ipr_src_out_t [ipr_pkg::NUM_SRC-1:0]    dec;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  ipr_apb_decode u_apb_decode (
    .req_i    (apb_req_i),
    .setup_o  (bus_setup),
    .access_o (bus_access),
    .hit_o    (bus_hit),
    .sel_o    (bus_sel)
  );

  // Write lands only on the access cycle that sees pready high
  assign wr_commit = bus_access & s_reg.rsp.pready & apb_req_i.pwrite
                   & bus_hit;
  assign wr_data   = apb_req_i.pwdata[ipr_pkg::REG_W-1:0];

  // ---------------------------------------------------------------
  // Field extraction toward the per-source decoders
  // ---------------------------------------------------------------
  always_comb begin
    fld[ipr_pkg::SRC_PORT_C_PIN] =
      s_reg.prio_4[ipr_pkg::LSB_PORT_C_PIN +: ipr_pkg::FLD_W];
    fld[ipr_pkg::SRC_DEC1_INDEX] =
      s_reg.prio_5[ipr_pkg::LSB_DEC1_INDEX +: ipr_pkg::FLD_W];
    fld[ipr_pkg::SRC_DEC1_HOME_WDOG] =
      s_reg.prio_5[ipr_pkg::LSB_DEC1_HOME_WDOG +: ipr_pkg::FLD_W];
    fld[ipr_pkg::SRC_SER1_RX_FULL] =
      s_reg.prio_5[ipr_pkg::LSB_SER1_RX_FULL +: ipr_pkg::FLD_W];
    fld[ipr_pkg::SRC_SER1_RX_ERROR] =
      s_reg.prio_5[ipr_pkg::LSB_SER1_RX_ERROR +: ipr_pkg::FLD_W];
    fld[ipr_pkg::SRC_SER1_TX_IDLE] =
      s_reg.prio_5[ipr_pkg::LSB_SER1_TX_IDLE +: ipr_pkg::FLD_W];
    fld[ipr_pkg::SRC_SER1_TX_EMPTY] =
      s_reg.prio_5[ipr_pkg::LSB_SER1_TX_EMPTY +: ipr_pkg::FLD_W];
    fld[ipr_pkg::SRC_SPI0_TX_EMPTY] =
      s_reg.prio_5[ipr_pkg::LSB_SPI0_TX_EMPTY +: ipr_pkg::FLD_W];
    fld[ipr_pkg::SRC_TMR3_CH0] =
      s_reg.prio_6[ipr_pkg::LSB_TMR3_CH0 +: ipr_pkg::FLD_W];
    fld[ipr_pkg::SRC_TMR4_CH3] =
      s_reg.prio_6[ipr_pkg::LSB_TMR4_CH3 +: ipr_pkg::FLD_W];
    fld[ipr_pkg::SRC_TMR4_CH2] =
      s_reg.prio_6[ipr_pkg::LSB_TMR4_CH2 +: ipr_pkg::FLD_W];
    fld[ipr_pkg::SRC_TMR4_CH1] =
      s_reg.prio_6[ipr_pkg::LSB_TMR4_CH1 +: ipr_pkg::FLD_W];
    fld[ipr_pkg::SRC_TMR4_CH0] =
      s_reg.prio_6[ipr_pkg::LSB_TMR4_CH0 +: ipr_pkg::FLD_W];
    fld[ipr_pkg::SRC_DEC0_INDEX] =
      s_reg.prio_6[ipr_pkg::LSB_DEC0_INDEX +: ipr_pkg::FLD_W];
    fld[ipr_pkg::SRC_DEC0_HOME_WDOG] =
      s_reg.prio_6[ipr_pkg::LSB_DEC0_HOME_WDOG +: ipr_pkg::FLD_W];
  end

  // ---------------------------------------------------------------
  // Per-source decoders
  // ---------------------------------------------------------------
  for (genvar k = 0; k < ipr_pkg::NUM_SRC; k++) begin : g_src
    ipr_field_decode u_field_decode (
      .code_i (fld[k]),
      .irq_i  (src_irq_i[k]),
      .out_o  (dec[k])
    );
  end

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;

    // One-cycle pready: raised after setup, dropped after access
    s_next.rsp.pready = bus_setup;

    // Read data and error captured in the setup cycle
    if (bus_setup) begin
      s_next.rsp.pslverr = ~bus_hit;
      s_next.rsp.prdata  = '0;
      unique case (1'b1)
        bus_sel[0]: s_next.rsp.prdata[ipr_pkg::REG_W-1:0] = s_reg.prio_4;
        bus_sel[1]: s_next.rsp.prdata[ipr_pkg::REG_W-1:0] = s_reg.prio_5;
        bus_sel[2]: s_next.rsp.prdata[ipr_pkg::REG_W-1:0] = s_reg.prio_6;
        default:    s_next.rsp.prdata = '0;
      endcase
    end

    if (wr_commit) begin
      unique case (1'b1)
        bus_sel[0]: s_next.prio_4 = wr_data & ipr_pkg::WMASK_PRIO_4;
        bus_sel[1]: s_next.prio_5 = wr_data & ipr_pkg::WMASK_PRIO_5;
        bus_sel[2]: s_next.prio_6 = wr_data & ipr_pkg::WMASK_PRIO_6;
        default:    s_next.prio_6 = s_reg.prio_6;
      endcase
    end

    // Registered per-source view
    for (int i = 0; i < ipr_pkg::NUM_SRC; i++) begin
      s_next.src_en[i]  = dec[i].enable;
      s_next.src_req[i] = dec[i].req;
      s_next.src_lvl[i] = dec[i].level;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s_reg        <= '0;
      s_reg.prio_4 <= ipr_pkg::RST_PRIO;
      s_reg.prio_5 <= ipr_pkg::RST_PRIO;
      s_reg.prio_6 <= ipr_pkg::RST_PRIO;
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ---------------------------------------------------------------
  assign apb_rsp_o   = s_reg.rsp;
  assign src_en_o    = s_reg.src_en;
  assign src_req_o   = s_reg.src_req;
  assign src_level_o = s_reg.src_lvl;

endmodule : ipr_prio_regs

/* File: bench/ipr_prio_regs_sva.sv */
// Concurrent checks on the ports of the priority register slice
module ipr_prio_regs_sva (
  // Clock and reset
  input wire logic                          ref_clk_i,
  input wire logic                          rst_n_i,
  // Bus
  input ipr_pkg::ipr_apb_req_t              apb_req_i,
  input ipr_pkg::ipr_apb_rsp_t              apb_rsp_o,
  // Sources
  input wire logic [ipr_pkg::NUM_SRC-1:0]   src_irq_i,
  input wire logic [ipr_pkg::NUM_SRC-1:0]   src_en_o,
  input wire logic [ipr_pkg::NUM_SRC-1:0]   src_req_o,
  input wire logic [ipr_pkg::NUM_SRC-1:0][1:0] src_level_o
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  logic lvl_ok;
  logic off_zero;

  // Level range and disabled-level flags over all sources
  always_comb begin
    lvl_ok = 1'b1;
    off_zero = 1'b1;
    for (int i = 0; i < ipr_pkg::NUM_SRC; i++) begin
      if (src_level_o[i] > ipr_pkg::LEVEL_MAX) lvl_ok = 1'b0;
      if (!src_en_o[i] && src_level_o[i] != 2'h0) off_zero = 1'b0;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Bus steps
  sequence setup_s;
    apb_req_i.psel && !apb_req_i.penable;
  endsequence
  sequence done_s;
    apb_req_i.psel && apb_req_i.penable && apb_rsp_o.pready;
  endsequence

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  pready_zero_wait_a: assert property (setup_s |=> apb_rsp_o.pready)
    else $error("pready missing in access cycle");
  pready_pulse_a: assert property (apb_rsp_o.pready |=> !apb_rsp_o.pready)
    else $error("pready held over two cycles");
  err_decode_a: assert property (done_s |-> apb_rsp_o.pslverr ==
    !(apb_req_i.paddr inside {12'h010, 12'h014, 12'h018}))
    else $error("pslverr wrong for address");
  rsvd5_read_a: assert property (done_s ##0 (apb_req_i.paddr == 12'h014)
    |-> apb_rsp_o.prdata[7:6] == 2'h0 && apb_rsp_o.prdata[31:16] == 16'h0)
    else $error("reserved bits of offset 5 not zero");
  rsvd6_read_a: assert property (done_s ##0 (apb_req_i.paddr == 12'h018)
    |-> apb_rsp_o.prdata[5:4] == 2'h0 && apb_rsp_o.prdata[31:16] == 16'h0)
    else $error("reserved bits of offset 6 not zero");
  off4_read_a: assert property (done_s ##0 (apb_req_i.paddr == 12'h010)
    |-> apb_rsp_o.prdata[31:2] == 30'h0)
    else $error("unused bits of offset 4 not zero");
  level_range_a: assert property (lvl_ok)
    else $error("level above two");
  disabled_level_a: assert property (off_zero)
    else $error("disabled source shows a level");
  req_gate_a: assert property (
    src_req_o == ($past(src_irq_i) & src_en_o))
    else $error("request not gated by enable");
  bad_write_a: assert property (done_s ##0 apb_rsp_o.pslverr
    |=> $stable(src_en_o) && $stable(src_level_o))
    else $error("refused write changed a field");
  reset_clear_a: assert property (disable iff (1'b0) !rst_n_i
    |=> src_en_o == 15'h0 && src_level_o == 30'h0 && src_req_o == 15'h0)
    else $error("outputs not cleared by reset");
endmodule : ipr_prio_regs_sva

bind ipr_prio_regs ipr_prio_regs_sva u_sva (
  .ref_clk_i, .rst_n_i, .apb_req_i, .apb_rsp_o,
  .src_irq_i, .src_en_o, .src_req_o, .src_level_o
);

/* File: bench/tb_ipr_prio_regs.sv */
// Self-checking bench for the priority register slice
module tb_ipr_prio_regs;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  ref_clk_i = 1'b0;
  logic                  rst_n_i   = 1'b0;
  ipr_pkg::ipr_apb_req_t req       = '0;
  ipr_pkg::ipr_apb_rsp_t rsp;
  logic [14:0]           irq       = 15'h0;
  logic [14:0]           en;
  logic [14:0]           rq;
  logic [14:0][1:0]      lvl;
  logic [15:0]           mdl [4:7];
  int                    mismatches  = 0;
  int                    comparisons = 0;
  int unsigned lsb_tab [15] = '{0, 14, 12, 10, 8, 4, 2, 0,
                                14, 12, 10, 8, 6, 2, 0};
  int unsigned reg_tab [15] = '{4, 5, 5, 5, 5, 5, 5, 5, 6, 6, 6, 6, 6, 6, 6};

  ipr_prio_regs dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .apb_req_i(req), .apb_rsp_o(rsp), .src_irq_i(irq),
    .src_en_o(en), .src_req_o(rq), .src_level_o(lvl));

  // 250 MHz clock
  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Verdict and end of run
  task automatic close_out();
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  // One APB transfer; register index idx, write mask applied in model
  task automatic apb(input logic wr, input int idx, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    logic [15:0] msk;
    int          n;
    @(posedge ref_clk_i);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= 12'(idx * 4);
    req.pwdata  <= d;
    @(posedge ref_clk_i);
    req.penable <= 1'b1;
    n = 0;
    // Sample the answer at the edge that sees pready high
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    rd  = rsp.prdata;
    err = rsp.pslverr;
    chk(32'(rsp.pready), 32'h1);
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    msk = (idx == 4) ? ipr_pkg::WMASK_PRIO_4 : (idx == 5) ?
      ipr_pkg::WMASK_PRIO_5 : ipr_pkg::WMASK_PRIO_6;
    chk(32'(err), 32'(idx < 4 || idx > 6));
    if (idx < 4 || idx > 6) chk(rd, 32'h0);
    else if (!wr) chk(rd, {16'h0, mdl[idx]});
    else mdl[idx] = d[15:0] & msk;
  endtask : apb

  // Decoded per-source view against the model
  task automatic chk_src();
    logic [1:0] c;
    logic [1:0] e;
    irq <= 15'($urandom);
    repeat (2) @(posedge ref_clk_i);
    #1;
    for (int i = 0; i < 15; i++) begin
      c = mdl[reg_tab[i]][lsb_tab[i] +: 2];
      e = (c == 2'h0) ? 2'h0 : 2'(c - 2'h1);
      chk(32'(en[i]), 32'(c != 2'h0));
      chk(32'(lvl[i]), 32'(e));
      chk(32'(rq[i]), 32'(irq[i] && c != 2'h0));
    end
  endtask : chk_src

  // Reset and clear the model
  task automatic do_reset();
    rst_n_i <= 1'b0;
    repeat (16) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    for (int i = 4; i < 8; i++) mdl[i] = 16'h0;
  endtask : do_reset

  // Watchdog
  initial begin
    #40000;
    mismatches++;
    close_out();
  end

  // Main sequence
  initial begin
    static logic [31:0] pat [4] = '{32'h0, 32'h5555, 32'hAAAA,
                                    32'hFFFFFFFF};
    void'($urandom(32'hD574));
    do_reset();
    for (int i = 4; i < 7; i++) apb(1'b0, i, 32'h0);
    chk_src();
    $display("test reset_values done");
    foreach (pat[k]) begin
      for (int i = 4; i < 7; i++) apb(1'b1, i, pat[k]);
      for (int i = 4; i < 7; i++) apb(1'b0, i, 32'h0);
      chk_src();
    end
    $display("test every_code done");
    apb(1'b1, 0, 32'h0);
    apb(1'b1, 7, 32'h0);
    apb(1'b0, 1023, 32'h0);
    chk_src();
    $display("test unmapped done");
    for (int t = 0; t < 60; t++) begin
      apb(1'($urandom), 4 + ($urandom % 4), $urandom);
      if (t % 4 == 3) chk_src();
    end
    $display("test random done");
    do_reset();
    for (int i = 4; i < 7; i++) apb(1'b0, i, 32'h0);
    chk_src();
    $display("test second_reset done");
    close_out();
  end
endmodule : tb_ipr_prio_regs
